// file: txf_tx_path.sv
// txf_tx_path: host write port, command parsing, payload trimming, data and status queues
// assumes a MAC engine on the same clock that drains tx_* and reports one result per packet
//
// Chosen here: the address-and-strobe port and the address map.
`default_nettype none
module txf_tx_path import txf_pkg::*; #(
   parameter int DATA_DEPTH = 64,
   parameter int STS_DEPTH = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // host register port
   input wire logic [3:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata,
   // payload stream to the MAC
   output logic tx_valid,
   input wire logic tx_ready,
   output logic [31:0] tx_data,
   output logic [3:0] tx_mask,
   output logic tx_last,
   output logic [15:0] tx_tag,
   // per-packet result from the MAC
   input wire logic tx_result_valid,
   input wire logic [15:0] tx_result,
   // flags and events
   output logic tx_error_flag,
   output logic tx_buffer_done_flag,
   output logic tx_error_evt,
   output logic sts_level_hit
);
   localparam int DAW = $clog2(DATA_DEPTH);
   localparam int SAW = $clog2(STS_DEPTH);
   localparam int EW = 53;
   txf_state_t st_reg, st_next;
   logic half_vld_reg, half_vld_next;
   logic [15:0] half_reg, half_next;
   logic [31:0] cmd_a_reg, cmd_a_next, pkt_b_reg, pkt_b_next;
   logic in_pkt_reg, in_pkt_next;
   logic [4:0] skip_reg, skip_next;
   logic [10:0] rem_reg, rem_next;
   logic [2:0] wcnt_reg, wcnt_next, pad_reg, pad_next;
   logic [11:0] pkt_bytes_reg, pkt_bytes_next;
   logic err_reg, err_next, done_reg, done_next, evt_reg, evt_next, lvl_reg, lvl_next;
   logic [7:0] level_reg, level_next;
   logic [15:0] rdata_reg, rdata_next;
   logic [DAW-1:0] dwp_reg, dwp_next, drp_reg, drp_next;
   logic [DAW:0] dcnt_reg, dcnt_next;
   logic ovld_reg, ovld_next;
   logic [SAW-1:0] swp_reg, swp_next, srp_reg, srp_next;
   logic [SAW:0] scnt_reg, scnt_next;
   logic shead_reg, shead_next;
   logic [15:0] tag_sent_reg, tag_sent_next;
   logic word_stb, err_set, fin, dpush, dpop, spush, spop, sfetch, flag_wr;
   logic [31:0] word;
   logic [2:0] lead, avail, take, wcnt_inc, align_m, pad_calc;
   logic [3:0] wmask;
   logic [10:0] rem_after, size_b;
   logic [EW-1:0] dout;
   logic [31:0] sts_out;
   logic [15:0] space_b, sts_used;
   // byte lanes of the current word that carry payload
   assign lead = (skip_reg >= 5'd4) ? 3'd4 : skip_reg[2:0];
   assign avail = 3'd4 - lead;
   assign take = (rem_reg < {8'h00, avail}) ? rem_reg[2:0] : avail;
   assign rem_after = rem_reg - {8'h00, take};
   assign wcnt_inc = wcnt_reg + 3'd1;
   assign align_m = (cmd_a_reg[CMDA_ALIGN_HI:CMDA_ALIGN_LO] == ALIGN_16) ? 3'd3 :
                    (cmd_a_reg[CMDA_ALIGN_HI:CMDA_ALIGN_LO] == ALIGN_32) ? 3'd7 : 3'd0;
   assign pad_calc = (3'd0 - wcnt_inc) & align_m;
   assign size_b = cmd_a_reg[CMDA_SIZE_HI:0];
   assign word = {wdata, half_reg};
   for (genvar gi = 0; gi < 4; gi++) begin : g_mask
      assign wmask[gi] = (3'(gi) >= lead) && (3'(gi) < lead + take);
   end
   always_comb begin
      st_next = st_reg;
      half_vld_next = half_vld_reg;
      half_next = half_reg;
      cmd_a_next = cmd_a_reg;
      pkt_b_next = pkt_b_reg;
      in_pkt_next = in_pkt_reg;
      skip_next = skip_reg;
      rem_next = rem_reg;
      wcnt_next = wcnt_reg;
      pad_next = pad_reg;
      pkt_bytes_next = pkt_bytes_reg;
      word_stb = 1'b0;
      err_set = 1'b0;
      fin = 1'b0;
      dpush = 1'b0;
      if (wr && addr == ADDR_DATA) begin
         // low half first, the high half completes the word
         half_vld_next = ~half_vld_reg;
         half_next = half_vld_reg ? half_reg : wdata;
         word_stb = half_vld_reg;
      end
      if (word_stb) begin
         case (st_reg)
            ST_CMD_A: begin
               cmd_a_next = word;
               st_next = ST_CMD_B;
            end
            ST_CMD_B: begin
               if (cmd_a_reg[CMDA_FIRST_BIT]) begin
                  err_set = in_pkt_reg;
                  pkt_b_next = word;
                  pkt_bytes_next = {1'b0, size_b};
               end else begin
                  // a continuation must repeat the opening buffer's second word
                  err_set = !in_pkt_reg || (word != pkt_b_reg);
                  pkt_bytes_next = pkt_bytes_reg + {1'b0, size_b};
               end
               in_pkt_next = 1'b1;
               skip_next = cmd_a_reg[CMDA_OFS_HI:CMDA_OFS_LO];
               rem_next = size_b;
               wcnt_next = 3'd0;
               if (size_b == 11'd0) begin
                  fin = 1'b1;
                  st_next = ST_CMD_A;
               end else begin
                  st_next = ST_DATA;
               end
            end
            ST_DATA: begin
               skip_next = skip_reg - {2'b00, lead};
               rem_next = rem_after;
               wcnt_next = wcnt_inc;
               if (take != 3'd0) begin
                  // full queue: the word is lost and the host is told
                  if (dcnt_reg == (DAW + 1)'(DATA_DEPTH)) begin
                     err_set = 1'b1;
                  end else begin
                     dpush = 1'b1;
                  end
               end
               if (rem_after == 11'd0) begin
                  pad_next = pad_calc;
                  if (pad_calc == 3'd0) begin
                     fin = 1'b1;
                     st_next = ST_CMD_A;
                  end else begin
                     st_next = ST_PAD;
                  end
               end
            end
            ST_PAD: begin
               pad_next = pad_reg - 3'd1;
               if (pad_reg == 3'd1) begin
                  fin = 1'b1;
                  st_next = ST_CMD_A;
               end
            end
            default: st_next = ST_CMD_A;
         endcase
      end
      if (fin && cmd_a_reg[CMDA_LAST_BIT]) begin
         in_pkt_next = 1'b0;
         if (pkt_bytes_next != {1'b0, pkt_b_next[CMDB_LEN_HI:0]}) begin
            err_set = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= ST_CMD_A;
         half_vld_reg <= 1'b0;
         half_reg <= 16'h0000;
         cmd_a_reg <= 32'h00000000;
         pkt_b_reg <= 32'h00000000;
         in_pkt_reg <= 1'b0;
         skip_reg <= 5'h00;
         rem_reg <= 11'h000;
         wcnt_reg <= 3'h0;
         pad_reg <= 3'h0;
         pkt_bytes_reg <= 12'h000;
      end else begin
         st_reg <= st_next;
         half_vld_reg <= half_vld_next;
         half_reg <= half_next;
         cmd_a_reg <= cmd_a_next;
         pkt_b_reg <= pkt_b_next;
         in_pkt_reg <= in_pkt_next;
         skip_reg <= skip_next;
         rem_reg <= rem_next;
         wcnt_reg <= wcnt_next;
         pad_reg <= pad_next;
         pkt_bytes_reg <= pkt_bytes_next;
      end
   end

   // data queue: one payload word plus byte lanes, end mark and tag per entry
   assign dpop = (dcnt_reg != '0) && (!ovld_reg || tx_ready);

   always_comb begin
      dwp_next = dpush ? dwp_reg + DAW'(1) : dwp_reg;
      drp_next = dpop ? drp_reg + DAW'(1) : drp_reg;
      dcnt_next = dcnt_reg + (DAW + 1)'(dpush) - (DAW + 1)'(dpop);
      ovld_next = dpop ? 1'b1 : (tx_ready ? 1'b0 : ovld_reg);
      tag_sent_next = (tx_valid && tx_ready && tx_last) ? tx_tag : tag_sent_reg;
   end

   txf_mem #(.WIDTH(EW), .DEPTH(DATA_DEPTH), .AW(DAW)) u_data_mem (
      .clk(clk),
      .rst_n(rst_n),
      .wr_en(dpush),
      .wr_addr(dwp_reg),
      .wr_data({pkt_b_next[CMDB_TAG_HI:CMDB_TAG_LO], cmd_a_reg[CMDA_LAST_BIT] && rem_after == 11'd0,
                wmask, word}),
      .rd_en(dpop),
      .rd_addr(drp_reg),
      .rd_data(dout)
   );

   assign tx_valid = ovld_reg;
   assign tx_data = dout[31:0];
   assign tx_mask = dout[35:32];
   assign tx_last = dout[36];
   assign tx_tag = dout[52:37];

   // status queue with a prefetched head so a host read never waits
   assign spush = tx_result_valid && (scnt_reg != (SAW + 1)'(STS_DEPTH));
   assign spop = rd && addr == ADDR_STS_HI && shead_reg;
   assign sfetch = (scnt_reg != '0) && (!shead_reg || spop);

   always_comb begin
      swp_next = spush ? swp_reg + SAW'(1) : swp_reg;
      srp_next = sfetch ? srp_reg + SAW'(1) : srp_reg;
      scnt_next = scnt_reg + (SAW + 1)'(spush) - (SAW + 1)'(sfetch);
      shead_next = sfetch ? 1'b1 : (spop ? 1'b0 : shead_reg);
   end

   txf_mem #(.WIDTH(32), .DEPTH(STS_DEPTH), .AW(SAW)) u_sts_mem (
      .clk(clk),
      .rst_n(rst_n),
      .wr_en(spush),
      .wr_addr(swp_reg),
      .wr_data({tag_sent_reg, tx_result}),
      .rd_en(sfetch),
      .rd_addr(srp_reg),
      .rd_data(sts_out)
   );

   assign space_b = 16'(((DAW + 1)'(DATA_DEPTH) - dcnt_reg) * 4);
   assign sts_used = 16'(scnt_reg) + 16'(shead_reg);
   assign flag_wr = wr && addr == ADDR_FLAGS;

   // flags: hardware set wins over a host clear in the same cycle
   always_comb begin
      err_next = err_set | (err_reg & ~(flag_wr & wdata[FLG_ERR]));
      done_next = (fin & cmd_a_reg[CMDA_IOC_BIT]) | (done_reg & ~(flag_wr & wdata[FLG_DONE]));
      evt_next = err_set & ~err_reg;
      lvl_next = (level_reg != 8'h00) && (sts_used >= {8'h00, level_reg});
      level_next = (wr && addr == ADDR_LEVEL) ? wdata[7:0] : level_reg;
      rdata_next = 16'h0000;
      if (rd) begin
         case (addr)
            ADDR_STS_LO: rdata_next = shead_reg ? sts_out[15:0] : 16'h0000;
            ADDR_STS_HI: rdata_next = shead_reg ? sts_out[31:16] : 16'h0000;
            ADDR_SPACE: rdata_next = space_b;
            ADDR_STS_USED: rdata_next = sts_used;
            ADDR_FLAGS: rdata_next = {13'h0000, lvl_reg, done_reg, err_reg};
            ADDR_LEVEL: rdata_next = {8'h00, level_reg};
            default: rdata_next = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dwp_reg <= '0;
         drp_reg <= '0;
         dcnt_reg <= '0;
         ovld_reg <= 1'b0;
         tag_sent_reg <= 16'h0000;
         swp_reg <= '0;
         srp_reg <= '0;
         scnt_reg <= '0;
         shead_reg <= 1'b0;
         err_reg <= 1'b0;
         done_reg <= 1'b0;
         evt_reg <= 1'b0;
         lvl_reg <= 1'b0;
         level_reg <= LEVEL_RST;
         rdata_reg <= 16'h0000;
      end else begin
         dwp_reg <= dwp_next;
         drp_reg <= drp_next;
         dcnt_reg <= dcnt_next;
         ovld_reg <= ovld_next;
         tag_sent_reg <= tag_sent_next;
         swp_reg <= swp_next;
         srp_reg <= srp_next;
         scnt_reg <= scnt_next;
         shead_reg <= shead_next;
         err_reg <= err_next;
         done_reg <= done_next;
         evt_reg <= evt_next;
         lvl_reg <= lvl_next;
         level_reg <= level_next;
         rdata_reg <= rdata_next;
      end
   end

   assign rdata = rdata_reg;
   assign tx_error_flag = err_reg;
   assign tx_buffer_done_flag = done_reg;
   assign tx_error_evt = evt_reg;
   assign sts_level_hit = lvl_reg;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_err_sticky: assert property (err_reg && !(flag_wr && wdata[FLG_ERR]) |=> err_reg)
      else $error("error flag dropped without a clear");
   a_err_event: assert property ($rose(tx_error_flag) |-> tx_error_evt)
      else $error("no event on error flag set");
   a_tag_check: assert property (word_stb && st_reg == ST_CMD_B && !cmd_a_reg[CMDA_FIRST_BIT]
      && word[31:16] != pkt_b_reg[31:16] |=> tx_error_flag)
      else $error("tag mismatch not flagged");
   a_len_check: assert property (fin && cmd_a_reg[CMDA_LAST_BIT]
      && pkt_bytes_next != {1'b0, pkt_b_next[CMDB_LEN_HI:0]} |=> tx_error_flag)
      else $error("length mismatch not flagged");
   a_overfill: assert property (word_stb && st_reg == ST_DATA && take != 3'd0
      && dcnt_reg == (DAW + 1)'(DATA_DEPTH) |=> tx_error_flag && dcnt_reg <= (DAW + 1)'(DATA_DEPTH))
      else $error("overfill not flagged");
   a_no_cmd_store: assert property (word_stb && st_reg != ST_DATA |=> dcnt_reg <= $past(dcnt_reg))
      else $error("non-payload word stored");
   a_word_pair: assert property ((wr && addr == ADDR_DATA && !half_vld_reg) ##1 (wr && addr == ADDR_DATA)
      |-> word_stb)
      else $error("half-word pair not assembled");
   a_done_flag: assert property (fin && cmd_a_reg[CMDA_IOC_BIT] |=> tx_buffer_done_flag)
      else $error("done flag missing after buffer");
   a_sts_tag: assert property (spush && scnt_reg == '0 && !shead_reg
      |-> ##2 (shead_reg && sts_out[31:16] == $past(tag_sent_reg, 2)))
      else $error("status head wrong tag");
   a_space_read: assert property (rd && addr == ADDR_SPACE |=> rdata == $past(space_b))
      else $error("space read wrong");

   c_buf_done: cover property (fin && cmd_a_reg[CMDA_IOC_BIT]);
   c_multi_buf: cover property (word_stb && st_reg == ST_CMD_B && !cmd_a_reg[CMDA_FIRST_BIT] && !err_set);
   c_padding: cover property (st_reg == ST_PAD ##1 st_reg == ST_CMD_A);
   c_sts_pop: cover property (spop);
endmodule : txf_tx_path
`default_nettype wire

// file: txf_pkg.sv
// txf_pkg: shared constants for the transmit command/data front end
// assumes a 16-bit host register port and a single 40 MHz system clock
`default_nettype none
package txf_pkg;
   // host register byte addresses
   localparam logic [3:0] ADDR_DATA = 4'h0;
   localparam logic [3:0] ADDR_STS_LO = 4'h2;
   localparam logic [3:0] ADDR_STS_HI = 4'h4;
   localparam logic [3:0] ADDR_SPACE = 4'h6;
   localparam logic [3:0] ADDR_STS_USED = 4'h8;
   localparam logic [3:0] ADDR_FLAGS = 4'hA;
   localparam logic [3:0] ADDR_LEVEL = 4'hC;
   // first command word fields
   localparam int CMDA_IOC_BIT = 31;
   localparam int CMDA_ALIGN_HI = 25;
   localparam int CMDA_ALIGN_LO = 24;
   localparam int CMDA_OFS_HI = 20;
   localparam int CMDA_OFS_LO = 16;
   localparam int CMDA_FIRST_BIT = 13;
   localparam int CMDA_LAST_BIT = 12;
   localparam int CMDA_SIZE_HI = 10;
   // second command word fields
   localparam int CMDB_TAG_HI = 31;
   localparam int CMDB_TAG_LO = 16;
   localparam int CMDB_LEN_HI = 10;
   // end alignment codes
   localparam logic [1:0] ALIGN_16 = 2'h1;
   localparam logic [1:0] ALIGN_32 = 2'h2;
   // flag register bits
   localparam int FLG_ERR = 0;
   localparam int FLG_DONE = 1;
   localparam int FLG_LEVEL = 2;
   // reset values
   localparam logic [7:0] LEVEL_RST = 8'h00;
   typedef enum logic [1:0] {ST_CMD_A, ST_CMD_B, ST_DATA, ST_PAD} txf_state_t;
endpackage : txf_pkg
`default_nettype wire

// file: txf_mem.sv
// txf_mem: simple dual-port storage with a registered read port
// assumes the caller never reads and writes one address in the same cycle
`default_nettype none
module txf_mem #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16,
   parameter int AW = 4
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // write port
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   // read port
   input wire logic rd_en,
   input wire logic [AW-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data
);
   logic [WIDTH-1:0] mem [DEPTH];

   // array itself is not reset: contents are only read after a write
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= '0;
      end else if (rd_en) begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule : txf_mem
`default_nettype wire

// file: txf_mac_model.sv
// txf_mac_model: transmit engine stand-in that drains the payload stream
// assumes the design's clock; stall holds ready low so the data queue can fill
`default_nettype none
module txf_mac_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // test control
   input wire logic stall,
   // payload stream
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic [3:0] tx_mask,
   input wire logic [31:0] tx_data,
   input wire logic tx_last,
   // per-packet result
   output logic tx_result_valid,
   output logic [15:0] tx_result,
   output logic [15:0] sum_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] byte_cnt;
   logic [15:0] nb;
   logic [15:0] sum_acc;
   logic [15:0] sum_nb;
   integer seed = 32'h93160D32;
   // byte sum of the kept lanes, so a wrong lane or a kept pad byte shows up
   assign sum_nb = sum_acc + (tx_mask[0] ? 16'(tx_data[7:0]) : 16'h0000)
                   + (tx_mask[1] ? 16'(tx_data[15:8]) : 16'h0000)
                   + (tx_mask[2] ? 16'(tx_data[23:16]) : 16'h0000)
                   + (tx_mask[3] ? 16'(tx_data[31:24]) : 16'h0000);
   // result carries the byte count seen, so trimming errors show in the status word
   assign nb = byte_cnt + 16'(tx_mask[0]) + 16'(tx_mask[1]) + 16'(tx_mask[2]) + 16'(tx_mask[3]);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_ready <= 1'b0;
         tx_result_valid <= 1'b0;
         tx_result <= 16'h0000;
         byte_cnt <= 16'h0000;
         sum_acc <= 16'h0000;
         sum_out <= 16'h0000;
      end else begin
         tx_ready <= !stall && ($random(seed) & 1);
         tx_result_valid <= 1'b0;
         // stale result must never look like a fresh one
         tx_result <= ~tx_result;
         if (tx_valid && tx_ready) begin
            byte_cnt <= tx_last ? 16'h0000 : nb;
            sum_acc <= tx_last ? 16'h0000 : sum_nb;
            if (tx_last) begin
               tx_result_valid <= 1'b1;
               tx_result <= nb;
               sum_out <= sum_nb;
            end
         end
      end
   end
endmodule : txf_mac_model
`default_nettype wire

// file: txf_tx_path_tb_top.sv
// txf_tx_path_tb_top: random and corner buffers through the host port, checked at registers, flag outputs and the engine's byte sum
// assumes txf_mac_model drains the stream and reports the byte count as the result
`default_nettype none
module txf_tx_path_tb_top import txf_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int DD = 8;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic stall = 1'b0;
   logic [15:0] rdata;
   logic tx_valid, tx_ready, tx_last, res_v, err_f, done_f, err_evt, lvl_hit;
   logic [3:0] tx_mask;
   logic [15:0] res;
   logic [31:0] tx_data;
   logic [15:0] sum_seen;
   logic [15:0] exp_sum = 16'h0000;
   int failures = 0;
   int check_count = 0;
   int evt_n = 0;
   integer seed = 32'h93160D32;

   always #12.5 clk = ~clk;
   always @(posedge clk) if (err_evt === 1'b1) evt_n++;

   txf_tx_path #(.DATA_DEPTH(DD), .STS_DEPTH(4)) uut (
      .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_mask(tx_mask), .tx_last(tx_last),
      .tx_tag(), .tx_result_valid(res_v), .tx_result(res), .tx_error_flag(err_f),
      .tx_buffer_done_flag(done_f), .tx_error_evt(err_evt), .sts_level_hit(lvl_hit));

   txf_mac_model mac (
      .clk(clk), .rst_n(rst_n), .stall(stall), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .tx_mask(tx_mask), .tx_data(tx_data), .tx_last(tx_last), .tx_result_valid(res_v), .tx_result(res),
      .sum_out(sum_seen));

   task automatic print_verdict();
      $display("checks=%0d failures=%0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : print_verdict

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic wr16(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr16

   task automatic rd16(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask : rd16

   // both halves back to back, strobe held high across them
   task automatic wr32(input logic [31:0] w);
      @(posedge clk);
      addr <= ADDR_DATA;
      wdata <= w[15:0];
      wr <= 1'b1;
      @(posedge clk);
      wdata <= w[31:16];
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr32

   function automatic int pad_words(input int pw, input logic [1:0] al);
      int n;
      n = (al == ALIGN_16) ? 4 : (al == ALIGN_32) ? 8 : 1;
      return (n - pw % n) % n;
   endfunction : pad_words

   task automatic send_buf(input logic ioc, input logic [1:0] al, input logic [4:0] ofs, input logic fb,
                           input logic lb, input logic [10:0] size, input logic [15:0] tag, input logic [10:0] len);
      int pw;
      logic [31:0] w;
      pw = (size == 0) ? 0 : (ofs + size + 3) / 4;
      wr32({ioc, 5'h00, al, 3'h0, ofs, 2'h0, fb, lb, 1'b0, size});
      wr32({tag, 5'h00, len});
      for (int k = 0; k < pw + pad_words(pw, al); k++) begin
         w = $random(seed);
         for (int b = 0; b < 4; b++) begin
            if (k * 4 + b >= ofs && k * 4 + b < ofs + size) begin
               exp_sum += w[8 * b +: 8];
            end
         end
         wr32(w);
      end
   endtask : send_buf

   task automatic wait_sts();
      logic [15:0] d;
      for (int i = 0; i < 300; i++) begin
         rd16(ADDR_STS_USED, d);
         if (d !== 16'h0000) return;
      end
      failures++;
      print_verdict();
   endtask : wait_sts

   initial begin
      logic [15:0] d, tag;
      logic [10:0] s1, s2;
      logic [4:0] o1, o2;
      int e0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      rd16(ADDR_SPACE, d);
      check(d, 16'(DD * 4));
      rd16(ADDR_LEVEL, d);
      check(d, {8'h00, LEVEL_RST});
      rd16(4'hE, d);
      check(d, 16'h0000);
      wr16(ADDR_LEVEL, 16'h0001);
      // every alignment code, single and split packets; first pass uses the widest offset
      for (int i = 0; i < 8; i++) begin
         exp_sum = 16'h0000;
         tag = 16'($random(seed));
         s1 = (i == 0) ? 11'h001 : 11'(1 + ($random(seed) & 15));
         s2 = 11'(1 + ($random(seed) & 15));
         o1 = (i == 0) ? 5'h1F : 5'($random(seed));
         o2 = 5'($random(seed));
         if (i[0]) begin
            send_buf(1'b0, i[2:1], o1, 1'b1, 1'b0, s1, tag, s1 + s2);
            send_buf(1'b1, i[2:1], o2, 1'b0, 1'b1, s2, tag, s1 + s2);
         end else begin
            send_buf(1'b1, i[2:1], o1, 1'b1, 1'b1, s1, tag, s1);
         end
         rd16(ADDR_FLAGS, d);
         check(d & 16'h0003, 16'h0002);
         wait_sts();
         repeat (2) @(posedge clk);
         rd16(ADDR_FLAGS, d);
         check({15'h0000, d[2]}, 16'h0001);
         check({14'h0000, lvl_hit, done_f}, 16'h0003);
         rd16(ADDR_STS_LO, d);
         check(d, 16'(i[0] ? s1 + s2 : s1));
         rd16(ADDR_STS_HI, d);
         check(d, tag);
         check(sum_seen, exp_sum);
         wr16(ADDR_FLAGS, 16'h0003);
         rd16(ADDR_FLAGS, d);
         check(d, 16'h0000);
         rd16(ADDR_SPACE, d);
         check(d, 16'(DD * 4));
      end
      // error cases: tag mismatch, length mismatch, overfill while the engine stalls
      for (int e = 0; e < 3; e++) begin
         e0 = evt_n;
         @(posedge clk);
         stall <= (e == 2);
         tag = 16'($random(seed));
         case (e)
            0: begin
               send_buf(1'b0, 2'h0, 5'h00, 1'b1, 1'b0, 11'h004, tag, 11'h008);
               send_buf(1'b0, 2'h0, 5'h00, 1'b0, 1'b1, 11'h004, tag ^ 16'h0001, 11'h008);
            end
            1: send_buf(1'b0, 2'h0, 5'h01, 1'b1, 1'b1, 11'h006, tag, 11'h007);
            default: send_buf(1'b0, 2'h0, 5'h00, 1'b1, 1'b1, 11'(DD * 4 + 8), tag, 11'(DD * 4 + 8));
         endcase
         rd16(ADDR_FLAGS, d);
         check(d & 16'h0003, 16'h0001);
         check({15'h0000, err_f}, 16'h0001);
         check(16'(evt_n - e0), 16'h0001);
         wr16(ADDR_FLAGS, 16'h0001);
         @(posedge clk);
         stall <= 1'b0;
         repeat (60) @(posedge clk);
         rd16(ADDR_FLAGS, d);
         check(d & 16'h0003, 16'h0000);
      end
      print_verdict();
   end
endmodule : txf_tx_path_tb_top
`default_nettype wire
